// >>> design/timer8_pkg.sv
// Register map, field positions, reset values and prescaler constants of the 8-bit timer.
package timer8_pkg;
  localparam logic [5:0] ADDR_COMPARE_VALUE = 6'h23;
  localparam logic [5:0] ADDR_COUNTER_VALUE = 6'h24;
  localparam logic [5:0] ADDR_TIMER_CONTROL = 6'h25;
  localparam logic [5:0] ADDR_IRQ_FLAG = 6'h36;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h37;

  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_WGM0_BIT = 6;
  localparam int CTRL_COM1_BIT = 5;
  localparam int CTRL_COM0_BIT = 4;
  localparam int CTRL_WGM1_BIT = 3;
  localparam int CTRL_CS_LSB = 0;
  localparam int IRQ_COMPARE_BIT = 7;
  localparam int IRQ_OVERFLOW_BIT = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE_PWM = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_A = 3'h6;
  localparam logic [2:0] CS_EXT_B = 3'h7;

  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03F;
  localparam logic [9:0] MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_e;
endpackage : timer8_pkg

// >>> design/pin_fall_detect.sv
// Synchroniser and falling-edge detector for the external count input.
`timescale 1ns/1ps
module pin_fall_detect
  import timer8_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  output logic fall_o
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic fall;
  } fall_state_s;

  fall_state_s state_reg;
  fall_state_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.sync1 = pin_i;
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    state_next.fall = state_reg.prev & ~state_reg.sync2;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fall_o = state_reg.fall;
endmodule : pin_fall_detect

// >>> design/timer8_prescaler.sv
// Prescaler that turns the clock-select code into a one-cycle timer clock enable.
`timescale 1ns/1ps
module timer8_prescaler
  import timer8_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] clock_source_select_i,
  input wire logic ext_fall_i,
  output logic tick_o
);
  typedef struct packed {
    logic [9:0] count;
    logic tick;
  } prescale_state_s;

  prescale_state_s state_reg;
  prescale_state_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.count = state_reg.count + 10'h001;
    case (clock_source_select_i)
      CS_STOP: state_next.tick = 1'b0;
      CS_DIV1: state_next.tick = 1'b1;
      CS_DIV8: state_next.tick = (state_reg.count & MASK_DIV8) == MASK_DIV8;
      CS_DIV64: state_next.tick = (state_reg.count & MASK_DIV64) == MASK_DIV64;
      CS_DIV256: state_next.tick = (state_reg.count & MASK_DIV256) == MASK_DIV256;
      CS_DIV1024: state_next.tick = (state_reg.count & MASK_DIV1024) == MASK_DIV1024;
      CS_EXT_A, CS_EXT_B: state_next.tick = ext_fall_i;
      default: state_next.tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '{count: PRESCALE_RESET, tick: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o = state_reg.tick;
endmodule : timer8_prescaler

// >>> design/timer8_compare_output_ctrl.sv
// 8-bit timer/counter with one compare unit, waveform output and I/O register access.
// How it works
// - Nonzero output mode overrides port data; pin drives only when direction bit set.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at bottom, 11 inverse, 01 reserved.
// - Fast PWM with compare at top and upper mode bit: skip match, act at bottom.
// - Phase PWM: 10 clears on up-match, sets on down-match; 11 opposite.
// - Phase PWM with compare at top and upper mode bit: skip match, act at top.
// - Clock select 000 stops; 001..101 divide I/O clock by 1,8,64,256,1024.
// - Clock select 110 and 111 count falling edges of external count pin.
// - External pin counts even while configured as output.
// - Software reads and writes the full 8-bit counter directly.
// - Counter write suppresses compare match on the next timer tick.
// - Compare value is compared continuously; match feeds flag and waveform.
// - Compare interrupt needs mask bit 7, global enable and compare flag.
// - Overflow interrupt needs mask bit 6, global enable and overflow flag.
// - Counter, compare and mask registers reset to zero.
// - Waveform modes: normal, phase PWM, clear-on-compare, fast PWM with their tops.
// - Flags clear on vector execution or writing one to the flag.
// - Phase PWM sets overflow flag at direction change at zero.
`timescale 1ns/1ps
module timer8_compare_output_ctrl
  import timer8_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [5:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic compare_vec_ack_i,
  input wire logic overflow_vec_ack_i,
  input wire logic ext_count_input_i,
  input wire logic port_data_i,
  input wire logic port_dir_i,
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic compare_output_pin_o,
  output logic compare_output_oe_o
);
  typedef struct packed {
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_output_mode;
    logic [2:0] clock_source_select;
    logic [7:0] compare_value;
    logic [7:0] counter_value;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic compare_match_flag;
    logic overflow_flag;
    count_dir_e dir;
    logic match_block;
    logic wave;
    logic [7:0] rdata;
    logic compare_irq;
    logic overflow_irq;
    logic pin_out;
    logic pin_oe;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;
  logic ext_fall;
  logic tick;

  pin_fall_detect u_fall (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .pin_i(ext_count_input_i),
    .fall_o(ext_fall)
  );

  timer8_prescaler u_prescale (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .clock_source_select_i(state_reg.clock_source_select),
    .ext_fall_i(ext_fall),
    .tick_o(tick)
  );

  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flag;
  logic wr_mask;
  logic [7:0] top;
  logic raw_match;
  logic match;
  logic top_special;
  logic set_cmp_flag;
  logic set_ovf_flag;
  logic [1:0] com;

  assign wr_ctrl = io_wr_i && io_addr_i == ADDR_TIMER_CONTROL;
  assign wr_cnt = io_wr_i && io_addr_i == ADDR_COUNTER_VALUE;
  assign wr_cmp = io_wr_i && io_addr_i == ADDR_COMPARE_VALUE;
  assign wr_flag = io_wr_i && io_addr_i == ADDR_IRQ_FLAG;
  assign wr_mask = io_wr_i && io_addr_i == ADDR_IRQ_MASK;
  assign com = state_reg.compare_output_mode;
  assign top = (state_reg.waveform_mode_select == WGM_CTC) ?
               state_reg.compare_value : COUNT_MAX;
  assign raw_match = state_reg.counter_value == state_reg.compare_value;
  assign match = tick && raw_match && !state_reg.match_block;
  assign top_special = state_reg.compare_value == COUNT_MAX && com[1];

  always_comb begin
    state_next = state_reg;
    set_cmp_flag = 1'b0;
    set_ovf_flag = 1'b0;
    if (tick) begin
      state_next.match_block = 1'b0;
      set_cmp_flag = match;
      case (state_reg.waveform_mode_select)
        WGM_PHASE_PWM: begin
          if (state_reg.dir == DIR_UP) begin
            if (state_reg.counter_value == COUNT_MAX) begin
              state_next.dir = DIR_DOWN;
              state_next.counter_value = state_reg.counter_value - 8'h01;
              if (top_special) begin
                state_next.wave = (com == COM_CLEAR);
              end
            end else begin
              state_next.counter_value = state_reg.counter_value + 8'h01;
            end
            if (match && !top_special && com[1]) begin
              state_next.wave = (com == COM_SET);
            end
          end else begin
            if (state_reg.counter_value == COUNT_BOTTOM) begin
              state_next.dir = DIR_UP;
              state_next.counter_value = state_reg.counter_value + 8'h01;
              set_ovf_flag = 1'b1;
            end else begin
              state_next.counter_value = state_reg.counter_value - 8'h01;
            end
            if (match && !top_special && com[1]) begin
              state_next.wave = (com == COM_CLEAR);
            end
          end
        end
        WGM_FAST_PWM: begin
          state_next.dir = DIR_UP;
          state_next.counter_value = state_reg.counter_value + 8'h01;
          if (state_reg.counter_value == COUNT_MAX) begin
            set_ovf_flag = 1'b1;
            if (com[1]) begin
              state_next.wave = (com == COM_CLEAR);
            end
          end else if (match && !top_special && com[1]) begin
            state_next.wave = (com == COM_SET);
          end
        end
        default: begin
          state_next.dir = DIR_UP;
          if (state_reg.counter_value == COUNT_MAX) begin
            set_ovf_flag = 1'b1;
          end
          if (state_reg.waveform_mode_select == WGM_CTC && state_reg.counter_value == top) begin
            state_next.counter_value = COUNT_BOTTOM;
          end else begin
            state_next.counter_value = state_reg.counter_value + 8'h01;
          end
          if (match) begin
            case (com)
              COM_TOGGLE: state_next.wave = ~state_reg.wave;
              COM_CLEAR: state_next.wave = 1'b0;
              COM_SET: state_next.wave = 1'b1;
              default: state_next.wave = state_reg.wave;
            endcase
          end
        end
      endcase
    end
    if (wr_ctrl) begin
      state_next.waveform_mode_select = {io_wdata_i[CTRL_WGM1_BIT], io_wdata_i[CTRL_WGM0_BIT]};
      state_next.compare_output_mode = {io_wdata_i[CTRL_COM1_BIT], io_wdata_i[CTRL_COM0_BIT]};
      state_next.clock_source_select = io_wdata_i[CTRL_CS_LSB +: 3];
      if (io_wdata_i[CTRL_FORCE_BIT] && !io_wdata_i[CTRL_WGM0_BIT]) begin
        case (state_reg.compare_output_mode)
          COM_TOGGLE: state_next.wave = ~state_reg.wave;
          COM_CLEAR: state_next.wave = 1'b0;
          COM_SET: state_next.wave = 1'b1;
          default: state_next.wave = state_reg.wave;
        endcase
      end
    end
    if (wr_cnt) begin
      state_next.counter_value = io_wdata_i;
      state_next.match_block = 1'b1;
    end
    if (wr_cmp) begin
      state_next.compare_value = io_wdata_i;
    end
    if (wr_mask) begin
      state_next.compare_irq_enable = io_wdata_i[IRQ_COMPARE_BIT];
      state_next.overflow_irq_enable = io_wdata_i[IRQ_OVERFLOW_BIT];
    end
    if (compare_vec_ack_i || (wr_flag && io_wdata_i[IRQ_COMPARE_BIT])) begin
      state_next.compare_match_flag = 1'b0;
    end
    if (overflow_vec_ack_i || (wr_flag && io_wdata_i[IRQ_OVERFLOW_BIT])) begin
      state_next.overflow_flag = 1'b0;
    end
    if (set_cmp_flag) begin
      state_next.compare_match_flag = 1'b1;
    end
    if (set_ovf_flag) begin
      state_next.overflow_flag = 1'b1;
    end
    state_next.compare_irq = state_reg.compare_irq_enable && global_irq_en_i &&
                             state_reg.compare_match_flag;
    state_next.overflow_irq = state_reg.overflow_irq_enable && global_irq_en_i &&
                              state_reg.overflow_flag;
    state_next.pin_out = (state_reg.compare_output_mode != COM_OFF) ?
                         state_reg.wave : port_data_i;
    state_next.pin_oe = port_dir_i;
    state_next.rdata = RESET_BYTE;
    if (io_rd_i) begin
      case (io_addr_i)
        ADDR_TIMER_CONTROL: state_next.rdata = {1'b0, state_reg.waveform_mode_select[0],
          state_reg.compare_output_mode, state_reg.waveform_mode_select[1],
          state_reg.clock_source_select};
        ADDR_COUNTER_VALUE: state_next.rdata = state_reg.counter_value;
        ADDR_COMPARE_VALUE: state_next.rdata = state_reg.compare_value;
        ADDR_IRQ_FLAG: state_next.rdata = {state_reg.compare_match_flag,
          state_reg.overflow_flag, 6'h00};
        ADDR_IRQ_MASK: state_next.rdata = {state_reg.compare_irq_enable,
          state_reg.overflow_irq_enable, 6'h00};
        default: state_next.rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
      state_reg.dir <= DIR_UP;
    end else begin
      state_reg <= state_next;
    end
  end

  assign io_rdata_o = state_reg.rdata;
  assign compare_irq_o = state_reg.compare_irq;
  assign overflow_irq_o = state_reg.overflow_irq;
  assign compare_output_pin_o = state_reg.pin_out;
  assign compare_output_oe_o = state_reg.pin_oe;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence counter_written_s;
    wr_cnt;
  endsequence

  sequence max_tick_s;
    tick && state_reg.counter_value == COUNT_MAX && com[1] && !wr_ctrl;
  endsequence

  cnt_write_block_a: assert property (counter_written_s ##1 (tick && raw_match) |=>
    !state_reg.compare_match_flag || $past(state_reg.compare_match_flag))
    else $error("compare flag set on tick right after counter write");
  stop_hold_a: assert property (state_reg.clock_source_select == CS_STOP && !wr_cnt
    && !$past(wr_ctrl) |=> $stable(state_reg.counter_value))
    else $error("counter moved while stopped");
  div1_count_a: assert property (state_reg.waveform_mode_select == WGM_NORMAL && tick
    && !wr_cnt |=> state_reg.counter_value == $past(state_reg.counter_value) + 8'h01)
    else $error("normal mode did not increment on tick");
  cmp_irq_gate_a: assert property (compare_irq_o |->
    $past(state_reg.compare_irq_enable) && $past(global_irq_en_i)
    && $past(state_reg.compare_match_flag))
    else $error("compare interrupt without all enables");
  ovf_irq_gate_a: assert property (overflow_irq_o |->
    $past(state_reg.overflow_irq_enable) && $past(global_irq_en_i)
    && $past(state_reg.overflow_flag))
    else $error("overflow interrupt without all enables");
  flag_clear_a: assert property (wr_flag && io_wdata_i[IRQ_COMPARE_BIT]
    && !set_cmp_flag |=> !state_reg.compare_match_flag)
    else $error("compare flag not cleared by write of one");
  pin_override_a: assert property (state_reg.compare_output_mode == COM_OFF
    |=> compare_output_pin_o == $past(port_data_i))
    else $error("disconnected output did not follow port data");
  phase_ovf_a: assert property (state_reg.waveform_mode_select == WGM_PHASE_PWM && tick
    && state_reg.dir == DIR_DOWN && state_reg.counter_value == COUNT_BOTTOM
    |=> state_reg.overflow_flag ##1 1'b1)
    else $error("phase pwm overflow flag not set at bottom");
  fast_bottom_a: assert property (state_reg.waveform_mode_select == WGM_FAST_PWM && tick
    && state_reg.counter_value == COUNT_MAX && com == COM_CLEAR && !wr_ctrl
    |=> state_reg.wave ##1 1'b1)
    else $error("fast pwm non-inverting output not set at bottom");
  phase_top_a: assert property (max_tick_s ##0 (top_special
    && state_reg.dir == DIR_UP && state_reg.waveform_mode_select == WGM_PHASE_PWM)
    |=> state_reg.wave == ($past(com) == COM_CLEAR))
    else $error("phase pwm top action wrong with compare at top");
  fast_top_a: assert property (max_tick_s ##0 (top_special
    && state_reg.waveform_mode_select == WGM_FAST_PWM)
    |=> state_reg.wave == ($past(com) == COM_CLEAR))
    else $error("fast pwm with compare at top missed bottom action");
  ctc_wrap_a: assert property (state_reg.waveform_mode_select == WGM_CTC && tick
    && state_reg.counter_value == top && !wr_cnt |=> state_reg.counter_value == COUNT_BOTTOM)
    else $error("clear-on-compare counter did not return to bottom");
  toggle_match_a: assert property (!state_reg.waveform_mode_select[0] && match
    && com == COM_TOGGLE && !wr_ctrl |=> state_reg.wave != $past(state_reg.wave))
    else $error("toggle mode did not invert output on match");
endmodule : timer8_compare_output_ctrl

// >>> tb/timer8_compare_output_ctrl_test.sv
// Self-checking testbench for the 8-bit timer with compare output and I/O registers.
`timescale 1ns/1ps
module timer8_compare_output_ctrl_test
  import timer8_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [5:0] io_addr_i = 6'h00;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic global_irq_en_i = 1'b0;
  logic compare_vec_ack_i = 1'b0;
  logic overflow_vec_ack_i = 1'b0;
  logic ext_count_input_i = 1'b1;
  logic port_data_i = 1'b0;
  logic port_dir_i = 1'b1;
  logic compare_irq_o;
  logic overflow_irq_o;
  logic compare_output_pin_o;
  logic compare_output_oe_o;
  int error_cnt = 0;
  int n_compared = 0;

  timer8_compare_output_ctrl DUT (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .global_irq_en_i(global_irq_en_i),
    .compare_vec_ack_i(compare_vec_ack_i),
    .overflow_vec_ack_i(overflow_vec_ack_i),
    .ext_count_input_i(ext_count_input_i),
    .port_data_i(port_data_i),
    .port_dir_i(port_dir_i),
    .compare_irq_o(compare_irq_o),
    .overflow_irq_o(overflow_irq_o),
    .compare_output_pin_o(compare_output_pin_o),
    .compare_output_oe_o(compare_output_oe_o)
  );

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic print_verdict;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : cmp1

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : idle

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge sys_clk_i);
    io_wr_i = 1'b0;
  endtask : wr

  // Read data is registered at the read edge and stands during the following cycle.
  task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp, input string msg);
    @(negedge sys_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge sys_clk_i);
    io_rd_i = 1'b0;
    cmp8(io_rdata_o, exp, msg);
  endtask : chk_reg

  function automatic logic [7:0] ctl(input logic [1:0] wgm, input logic [1:0] com,
                                     input logic [2:0] cs);
    logic [7:0] b;
    b = {5'h00, cs};
    b[CTRL_WGM1_BIT] = wgm[1];
    b[CTRL_WGM0_BIT] = wgm[0];
    b[CTRL_COM1_BIT] = com[1];
    b[CTRL_COM0_BIT] = com[0];
    return b;
  endfunction : ctl

  // Runs the timer for exactly n system cycles between the start and the stop write.
  task automatic run_timer(input logic [7:0] c, input int n);
    wr(ADDR_TIMER_CONTROL, c);
    idle(n - 2);
    wr(ADDR_TIMER_CONTROL, c & 8'hF8);
    idle(3);
  endtask : run_timer

  task automatic reset_and_access;
    logic [5:0] adr [6] = '{ADDR_COMPARE_VALUE, ADDR_COUNTER_VALUE, ADDR_TIMER_CONTROL,
                            ADDR_IRQ_FLAG, ADDR_IRQ_MASK, 6'h10};
    foreach (adr[i]) chk_reg(adr[i], RESET_BYTE, "reset value");
    cmp1(compare_irq_o, 1'b0, "compare irq after reset");
    wr(ADDR_COMPARE_VALUE, 8'hA5);
    chk_reg(ADDR_COMPARE_VALUE, 8'hA5, "compare rw");
    wr(ADDR_COUNTER_VALUE, 8'h5A);
    chk_reg(ADDR_COUNTER_VALUE, 8'h5A, "counter rw");
    wr(ADDR_IRQ_MASK, 8'hFF);
    chk_reg(ADDR_IRQ_MASK, 8'hC0, "mask bits");
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'hB8);
    chk_reg(ADDR_TIMER_CONTROL, 8'h38, "control force reads zero");
    wr(ADDR_TIMER_CONTROL, 8'h00);
    wr(6'h10, 8'hFF);
    chk_reg(6'h10, 8'h00, "unmapped address");
  endtask : reset_and_access

  task automatic prescaler_codes;
    logic [2:0] cs [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int dv [5] = '{1, 8, 64, 256, 1024};
    foreach (cs[i]) begin
      wr(ADDR_COUNTER_VALUE, 8'h00);
      run_timer(ctl(WGM_NORMAL, COM_OFF, cs[i]), 4 * dv[i]);
      idle(10);
      chk_reg(ADDR_COUNTER_VALUE, 8'h04, "four ticks per window");
    end
  endtask : prescaler_codes

  task automatic external_clock;
    logic [2:0] cs [2] = '{CS_EXT_A, CS_EXT_B};
    port_dir_i = 1'b1;
    foreach (cs[i]) begin
      wr(ADDR_COUNTER_VALUE, 8'h00);
      wr(ADDR_TIMER_CONTROL, ctl(WGM_NORMAL, COM_OFF, cs[i]));
      repeat (3) begin
        ext_count_input_i = 1'b0;
        idle(4);
        ext_count_input_i = 1'b1;
        idle(4);
      end
      idle(6);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      chk_reg(ADDR_COUNTER_VALUE, 8'h03, "falling edges counted");
    end
  endtask : external_clock

  task automatic interrupts;
    wr(ADDR_COMPARE_VALUE, 8'h05);
    wr(ADDR_COUNTER_VALUE, 8'h00);
    wr(ADDR_IRQ_FLAG, 8'hC0);
    run_timer(ctl(WGM_NORMAL, COM_OFF, CS_DIV1), 20);
    chk_reg(ADDR_IRQ_FLAG, 8'h80, "compare flag");
    cmp1(compare_irq_o, 1'b0, "irq while masked");
    wr(ADDR_IRQ_MASK, 8'h80);
    idle(2);
    cmp1(compare_irq_o, 1'b0, "irq without global enable");
    global_irq_en_i = 1'b1;
    idle(2);
    cmp1(compare_irq_o, 1'b1, "compare irq");
    compare_vec_ack_i = 1'b1;
    idle(1);
    compare_vec_ack_i = 1'b0;
    idle(2);
    cmp1(compare_irq_o, 1'b0, "irq after vector");
    wr(ADDR_COUNTER_VALUE, 8'h00);
    run_timer(ctl(WGM_NORMAL, COM_OFF, CS_DIV1), 20);
    cmp1(compare_irq_o, 1'b1, "compare irq again");
    wr(ADDR_IRQ_FLAG, 8'h80);
    idle(2);
    cmp1(compare_irq_o, 1'b0, "irq after write one");
    wr(ADDR_COMPARE_VALUE, 8'h80);
    wr(ADDR_COUNTER_VALUE, 8'hFD);
    run_timer(ctl(WGM_NORMAL, COM_OFF, CS_DIV1), 10);
    chk_reg(ADDR_COUNTER_VALUE, 8'h07, "wrap at 0xFF");
    chk_reg(ADDR_IRQ_FLAG, 8'h40, "overflow flag");
    cmp1(overflow_irq_o, 1'b0, "overflow irq masked");
    wr(ADDR_IRQ_MASK, 8'h40);
    idle(2);
    cmp1(overflow_irq_o, 1'b1, "overflow irq");
    overflow_vec_ack_i = 1'b1;
    idle(1);
    overflow_vec_ack_i = 1'b0;
    idle(2);
    cmp1(overflow_irq_o, 1'b0, "overflow irq after vector");
    chk_reg(ADDR_IRQ_FLAG, 8'h00, "flags clear");
    global_irq_en_i = 1'b0;
  endtask : interrupts

  task automatic non_pwm_output;
    logic [1:0] com [4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
    logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(ADDR_COMPARE_VALUE, 8'h03);
    foreach (com[i]) begin
      wr(ADDR_COUNTER_VALUE, 8'h00);
      run_timer(ctl(WGM_NORMAL, com[i], CS_DIV1), 12);
      cmp1(compare_output_pin_o, ex[i], "match action");
      cmp1(compare_output_oe_o, 1'b1, "driver enabled");
    end
    wr(ADDR_COUNTER_VALUE, 8'h10);
    wr(ADDR_IRQ_FLAG, 8'hC0);
    wr(ADDR_TIMER_CONTROL, ctl(WGM_NORMAL, COM_TOGGLE, CS_DIV1));
    wr(ADDR_COUNTER_VALUE, 8'h03);
    idle(3);
    wr(ADDR_TIMER_CONTROL, ctl(WGM_NORMAL, COM_TOGGLE, CS_STOP));
    cmp1(compare_output_pin_o, 1'b0, "match blocked after write");
    chk_reg(ADDR_IRQ_FLAG, 8'h00, "no flag after write");
    wr(ADDR_TIMER_CONTROL, ctl(WGM_NORMAL, COM_TOGGLE, CS_STOP) | 8'h80);
    idle(1);
    cmp1(compare_output_pin_o, 1'b1, "forced toggle");
    wr(ADDR_TIMER_CONTROL, 8'h00);
    port_data_i = 1'b1;
    idle(2);
    cmp1(compare_output_pin_o, 1'b1, "port data passes");
    port_dir_i = 1'b0;
    idle(2);
    cmp1(compare_output_oe_o, 1'b0, "driver off");
    port_dir_i = 1'b1;
    port_data_i = 1'b0;
    wr(ADDR_COUNTER_VALUE, 8'h00);
    run_timer(ctl(WGM_CTC, COM_OFF, CS_DIV1), 42);
    chk_reg(ADDR_COUNTER_VALUE, 8'h02, "ctc period of four");
  endtask : non_pwm_output

  task automatic pwm_output;
    wr(ADDR_COMPARE_VALUE, 8'h80);
    for (int k = 1; k >= 0; k--) begin
      wr(ADDR_COUNTER_VALUE, 8'hF0);
      run_timer(ctl(WGM_FAST_PWM, k ? COM_SET : COM_CLEAR, CS_DIV1), 8'hC0);
      cmp1(compare_output_pin_o, k[0], "fast pwm after match");
      run_timer(ctl(WGM_FAST_PWM, k ? COM_SET : COM_CLEAR, CS_DIV1), 100);
      cmp1(compare_output_pin_o, ~k[0], "fast pwm after bottom");
    end
    wr(ADDR_COUNTER_VALUE, 8'h00);
    run_timer(ctl(WGM_PHASE_PWM, COM_CLEAR, CS_DIV1), 8'hC0);
    cmp1(compare_output_pin_o, 1'b0, "phase pwm up match");
    wr(ADDR_IRQ_FLAG, 8'hC0);
    run_timer(ctl(WGM_PHASE_PWM, COM_CLEAR, CS_DIV1), 250);
    cmp1(compare_output_pin_o, 1'b1, "phase pwm down match");
    chk_reg(ADDR_IRQ_FLAG, 8'h80, "no overflow at top");
    run_timer(ctl(WGM_PHASE_PWM, COM_CLEAR, CS_DIV1), 100);
    chk_reg(ADDR_IRQ_FLAG, 8'hC0, "overflow at bottom");
  endtask : pwm_output

  // Compare at the top value: the output leaves its old level only through the top rules.
  task automatic top_compare;
    wr(ADDR_COMPARE_VALUE, 8'hFF);
    wr(ADDR_COUNTER_VALUE, 8'hF0);
    run_timer(ctl(WGM_PHASE_PWM, COM_SET, CS_DIV1), 30);
    cmp1(compare_output_pin_o, 1'b0, "phase pwm action at top");
    wr(ADDR_COUNTER_VALUE, 8'hF0);
    run_timer(ctl(WGM_FAST_PWM, COM_CLEAR, CS_DIV1), 30);
    cmp1(compare_output_pin_o, 1'b1, "fast pwm action at bottom only");
  endtask : top_compare

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    print_verdict();
  end

  initial begin
    idle(16);
    rstn_i = 1'b1;
    reset_and_access();
    prescaler_codes();
    external_clock();
    interrupts();
    non_pwm_output();
    pwm_output();
    top_compare();
    print_verdict();
  end
endmodule : timer8_compare_output_ctrl_test
